// ===== rtl/absh_pkg.sv
// Purpose: Shared constants and carrier types for the async strobe bus master
// Assumes: 50 MHz CLK; bus pins sampled through two-flop synchronisers
// Notes: Bus levels are electrical (low = asserted); user side is active high
package absh_pkg;

    localparam int ABSH_CLK_MHZ = 50;
    // Set-up and strobe-ownership wait times in ns
    localparam int ABSH_SETUP_NS = 40;
    localparam int ABSH_OWN_WAIT_NS = 60;
    localparam int ABSH_SETUP_CYC = (ABSH_SETUP_NS * ABSH_CLK_MHZ + 999) / 1000;
    localparam int ABSH_OWN_WAIT_CYC = (ABSH_OWN_WAIT_NS * ABSH_CLK_MHZ + 999) / 1000;
    localparam int ABSH_CNT_W = 8;
    localparam int ABSH_ADDR_W = 31;
    localparam int ABSH_DATA_W = 16;
    localparam int ABSH_IRQ_W = 7;
    localparam int ABSH_BREQ_W = 5;
    localparam logic [1:0] ABSH_SYNC_RESET = 2'h3;

    // One user request
    typedef struct packed {
        logic [ABSH_ADDR_W-1:0] addr;
        logic [ABSH_DATA_W-1:0] wdata;
        logic [1:0] lanes;
        logic read;
        logic wide;
    } absh_req_t;

    // Completion report
    typedef struct packed {
        logic [ABSH_DATA_W-1:0] rdata;
        logic fault;
    } absh_rsp_t;

    // Pin driver set for one three-state group
    typedef struct packed {
        logic addr_strobe_n;
        logic data_lane0_strobe_n;
        logic data_lane1_strobe_n;
    } absh_strobe_t;

endpackage

// ===== rtl/absh_sync.sv
// Purpose: Two-flop synchroniser for a group of bus pins
// Assumes: Inputs are asynchronous to CLK
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module absh_sync
    import absh_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // Released lines idle high, so reset to high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '1;
            dout <= '1;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // absh_sync

// ===== rtl/absh_master.sv
// Purpose: Master end of the asynchronous strobe bus, driving address/data strobes
// Assumes: One master owns the bus; the slave answers on open-collector lines
// Notes: All bus inputs synchronised; waits are in CLK cycles
// Function
// - Address valid before address strobe falls; fall marks address sampling.
// - Address strobe rise ends transfer and releases address lines.
// - Write data valid before a data strobe falls; slave captures its lanes.
// - On read slave drives lanes only after the matching data strobe falls.
// - Read strobe rises only after data taken; slave then releases lanes.
// - One driver at a time; undriven strobes read high.
// - New strobe owner sees it high, waits, then drives low.
// - Giving up a strobe may drive it high before releasing.
// - Write acknowledge fall means slave accepted data.
// - Read acknowledge fall means valid data on bus.
// - Read acknowledge rise means slave released data lines.
// - Acknowledge and fault are open-collector; falling edge signals response.
// - Shared lines decode by low level only, ignoring edges.
// - Low request or failure levels mean pending service or failure.
// - Interlocked signals stay in force until acknowledged.
// - Direction low for write, high read; wide low for 32-bit.
// - Level-significant lines encode logic one as low.
`timescale 1ns/100ps
module absh_master
    import absh_pkg::*;
#(
    parameter int SETUP_CYC = ABSH_SETUP_CYC,
    parameter int OWN_WAIT_CYC = ABSH_OWN_WAIT_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire absh_req_t REQ,
    output logic RSP_VALID,
    output absh_rsp_t RSP,
    output logic [ABSH_ADDR_W-1:0] ADDR_N_O,
    output logic ADDR_N_OE,
    output logic [ABSH_DATA_W-1:0] DATA_N_O,
    output logic DATA_N_OE,
    input wire logic [ABSH_DATA_W-1:0] DATA_N_I,
    output logic WRITE_N_O,
    output logic WIDE_XFER_N_O,
    output logic CTRL_N_OE,
    output absh_strobe_t STROBE_O,
    output logic STROBE_OE,
    input wire absh_strobe_t STROBE_I,
    input wire logic XFER_ACK_N,
    input wire logic BUS_FAULT_N,
    input wire logic [ABSH_IRQ_W-1:0] IRQ_LEVEL_N,
    input wire logic [ABSH_BREQ_W-1:0] BUS_REQ_LEVEL_N,
    input wire logic SYS_FAILURE_N,
    output logic [ABSH_IRQ_W-1:0] IRQ_PENDING,
    output logic [ABSH_BREQ_W-1:0] BUS_REQ_PENDING,
    output logic SYS_FAILED
);
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_OWN = 7'h02, S_ADDR = 7'h04, S_DSTB = 7'h08,
        S_ACK = 7'h10, S_REL = 7'h20, S_DREL = 7'h40
    } absh_state_t;

    localparam int SYNC_W = 3 + 2 + ABSH_IRQ_W + ABSH_BREQ_W + 1;

    absh_state_t state;
    logic [ABSH_CNT_W-1:0] cnt;
    absh_req_t cur;
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic [ABSH_DATA_W-1:0] data_s;
    absh_strobe_t stb_s;
    logic ack_s;
    logic fault_s;
    logic ack_d;
    logic fault_d;
    logic ack_fall;
    logic fault_fall;
    logic ack_rise;
    logic strobes_high;

    // All bus inputs pass two flops before use
    assign sync_in = {STROBE_I, XFER_ACK_N, BUS_FAULT_N, IRQ_LEVEL_N, BUS_REQ_LEVEL_N, SYS_FAILURE_N};
    absh_sync #(.WIDTH(SYNC_W)) u_ctl_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .din(sync_in),
        .dout(sync_out)
    );
    absh_sync #(.WIDTH(ABSH_DATA_W)) u_data_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .din(DATA_N_I),
        .dout(data_s)
    );
    assign stb_s = sync_out[SYNC_W-1 -: 3];
    assign ack_s = sync_out[SYNC_W-4];
    assign fault_s = sync_out[SYNC_W-5];

    // Shared lines: low level only, no edge detection at all
    assign IRQ_PENDING = ~sync_out[ABSH_BREQ_W+1 +: ABSH_IRQ_W];
    assign BUS_REQ_PENDING = ~sync_out[1 +: ABSH_BREQ_W];
    assign SYS_FAILED = ~sync_out[0];

    // Response-line edge history
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_d <= 1'b1;
            fault_d <= 1'b1;
        end else begin
            ack_d <= ack_s;
            fault_d <= fault_s;
        end
    end
    assign ack_fall = ack_d & ~ack_s;
    assign fault_fall = fault_d & ~fault_s;
    assign ack_rise = ~ack_d & ack_s;
    // Undriven strobes read high via termination
    assign strobes_high = &stb_s;

    assign REQ_READY = (state == S_IDLE);

    // Transfer sequencer; counters and response edges drive steps, ownership waits on steady strobe levels
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= S_IDLE;
            cnt <= '0;
            cur <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (REQ_VALID) begin
                        cur <= REQ;
                        cnt <= '0;
                        state <= S_OWN;
                    end
                end
                S_OWN: begin
                    // Need strobes seen high for the full wait before owning them
                    if (!strobes_high) begin
                        cnt <= '0;
                    end else if (cnt >= ABSH_CNT_W'(OWN_WAIT_CYC - 1)) begin
                        cnt <= '0;
                        state <= S_ADDR;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                S_ADDR: begin
                    // Address and data settle before any strobe falls
                    if (cnt >= ABSH_CNT_W'(SETUP_CYC - 1)) begin
                        cnt <= '0;
                        state <= S_DSTB;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                S_DSTB: begin
                    if (cnt >= ABSH_CNT_W'(SETUP_CYC - 1)) begin
                        cnt <= '0;
                        state <= S_ACK;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                S_ACK: begin
                    // Strobes held until slave answers; no timeout by design
                    if (ack_fall || fault_fall) begin
                        state <= S_REL;
                    end
                end
                S_REL: begin
                    // Read waits for acknowledge rise: data lines free again
                    if (!cur.read || ack_rise || ack_s) begin
                        state <= S_DREL;
                    end
                end
                S_DREL: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Read data captured on the acknowledge falling edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RSP <= '0;
            RSP_VALID <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            if (state == S_ACK && (ack_fall || fault_fall)) begin
                RSP.rdata <= cur.read ? ~data_s : '0;
                RSP.fault <= fault_fall;
            end
            if (state == S_DREL) begin
                RSP_VALID <= 1'b1;
            end
        end
    end

    // Pin drivers, all from flops
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ADDR_N_O <= '1;
            ADDR_N_OE <= 1'b0;
            DATA_N_O <= '1;
            DATA_N_OE <= 1'b0;
            WRITE_N_O <= 1'b1;
            WIDE_XFER_N_O <= 1'b1;
            CTRL_N_OE <= 1'b0;
            STROBE_O <= ABSH_SYNC_RESET == 2'h3 ? 3'h7 : 3'h7;
            STROBE_OE <= 1'b0;
        end else begin
            case (state)
                S_OWN: begin
                    if (strobes_high && cnt >= ABSH_CNT_W'(OWN_WAIT_CYC - 1)) begin
                        // Take the bus driving strobes high first
                        ADDR_N_O <= ~cur.addr;
                        ADDR_N_OE <= 1'b1;
                        WRITE_N_O <= cur.read;
                        WIDE_XFER_N_O <= ~cur.wide;
                        CTRL_N_OE <= 1'b1;
                        DATA_N_O <= ~cur.wdata;
                        DATA_N_OE <= ~cur.read;
                        STROBE_O <= 3'h7;
                        STROBE_OE <= 1'b1;
                    end
                end
                S_ADDR: begin
                    if (cnt >= ABSH_CNT_W'(SETUP_CYC - 1)) begin
                        STROBE_O.addr_strobe_n <= 1'b0;
                    end
                end
                S_DSTB: begin
                    if (cnt >= ABSH_CNT_W'(SETUP_CYC - 1)) begin
                        STROBE_O.data_lane0_strobe_n <= ~cur.lanes[0];
                        STROBE_O.data_lane1_strobe_n <= ~cur.lanes[1];
                    end
                end
                S_ACK: begin
                    if (ack_fall || fault_fall) begin
                        // Data taken, raise data strobes
                        STROBE_O.data_lane0_strobe_n <= 1'b1;
                        STROBE_O.data_lane1_strobe_n <= 1'b1;
                    end
                end
                S_REL: begin
                    if (!cur.read || ack_rise || ack_s) begin
                        STROBE_O.addr_strobe_n <= 1'b1;
                        DATA_N_OE <= 1'b0;
                    end
                end
                S_DREL: begin
                    // Strobes were driven high; now release everything
                    STROBE_OE <= 1'b0;
                    ADDR_N_OE <= 1'b0;
                    CTRL_N_OE <= 1'b0;
                end
                default: begin
                    STROBE_OE <= STROBE_OE;
                end
            endcase
        end
    end
endmodule // absh_master

// ===== tb/absh_master_asserts.sv
// Purpose: Pin-level protocol checks for the strobe bus master
// Assumes: One CLK domain, RST_N async active low
// Notes: Bound to absh_master from the bench top file
`timescale 1ns/100ps
module absh_master_asserts
    import absh_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RSP_VALID,
    input wire logic [ABSH_ADDR_W-1:0] ADDR_N_O,
    input wire logic ADDR_N_OE,
    input wire logic DATA_N_OE,
    input wire logic WRITE_N_O,
    input wire logic CTRL_N_OE,
    input wire absh_strobe_t STROBE_O,
    input wire logic STROBE_OE,
    input wire absh_strobe_t STROBE_I,
    input wire logic XFER_ACK_N,
    input wire logic BUS_FAULT_N,
    input wire logic [ABSH_IRQ_W-1:0] IRQ_LEVEL_N,
    input wire logic [ABSH_IRQ_W-1:0] IRQ_PENDING
);
    // Single domain, so clock and reset are stated once
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic ds_low;
    // Any data strobe driven low
    assign ds_low = STROBE_OE && !(STROBE_O.data_lane0_strobe_n && STROBE_O.data_lane1_strobe_n);
    a_addr_setup: assert property ($fell(STROBE_O.addr_strobe_n) |-> $past(ADDR_N_OE) && $stable(ADDR_N_O))
        else $error("address not set up before strobe");
    a_addr_held: assert property (STROBE_OE && !STROBE_O.addr_strobe_n |-> ADDR_N_OE && $stable(ADDR_N_O))
        else $error("address moved under strobe");
    a_wdata_setup: assert property ($rose(ds_low) && !WRITE_N_O |-> $past(DATA_N_OE))
        else $error("write data not set up");
    a_read_no_drive: assert property (CTRL_N_OE && WRITE_N_O |-> !DATA_N_OE)
        else $error("master drives data on read");
    a_strobe_interlock: assert property (ds_low && XFER_ACK_N && BUS_FAULT_N |=> ds_low)
        else $error("data strobe dropped before answer");
    a_read_rise_late: assert property ($fell(ds_low) && WRITE_N_O |-> !$past(XFER_ACK_N) || !$past(BUS_FAULT_N))
        else $error("read strobe rose without answer");
    a_answer_ends: assert property ($fell(XFER_ACK_N && BUS_FAULT_N) |-> ##[1:30] RSP_VALID)
        else $error("answer did not end transfer");
    // Strobe levels reach the sequencer two flops late, so the high window sits 3 to 5 samples back
    a_own_high: assert property ($rose(STROBE_OE) |-> STROBE_O == 3'h7 && $past(STROBE_I == 3'h7, 3)
        && $past(STROBE_I == 3'h7, 4) && $past(STROBE_I == 3'h7, 5))
        else $error("strobe taken while not high");
    a_irq_level: assert property (IRQ_PENDING == ~$past(IRQ_LEVEL_N, 2))
        else $error("request level not decoded");
    // Main scenarios reached
    c_write: cover property ($fell(ds_low) && !WRITE_N_O);
    c_read: cover property ($fell(ds_low) && WRITE_N_O);
    c_fault: cover property ($fell(BUS_FAULT_N));
endmodule // absh_master_asserts

// ===== tb/absh_slave_model.sv
// Purpose: Behavioural addressed slave on the strobe bus
// Assumes: Strobes resolved by the bench, high when undriven
// Notes: Strobe edges start a transfer, high data strobe levels end it; a 16-word store backs it
`timescale 1ns/100ps
module absh_slave_model
    import absh_pkg::*;
(
    input wire logic clk,
    input wire absh_strobe_t strobe,
    input wire logic [ABSH_ADDR_W-1:0] addr_n,
    input wire logic write_n,
    input wire logic [ABSH_DATA_W-1:0] data_n,
    input wire logic [3:0] delay,
    input wire logic fault,
    output logic [ABSH_DATA_W-1:0] rdata_n,
    output logic rdata_oe,
    output logic ack_n,
    output logic fault_n
);
    logic [ABSH_DATA_W-1:0] mem [0:15];
    logic [ABSH_ADDR_W-1:0] last_addr;
    logic last_write;
    logic [1:0] lanes;
    // Idle: lines released
    initial begin
        rdata_n = 16'h5A5A;
        rdata_oe = 1'h0;
        ack_n = 1'h1;
        fault_n = 1'h1;
        for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    end
    // One transfer per address strobe fall
    always begin
        @(negedge strobe.addr_strobe_n);
        last_addr = ~addr_n;
        @(negedge strobe.data_lane0_strobe_n or negedge strobe.data_lane1_strobe_n);
        #1;
        lanes = ~{strobe.data_lane1_strobe_n, strobe.data_lane0_strobe_n};
        last_write = !write_n;
        if (last_write && lanes[0]) mem[last_addr[3:0]][7:0] = ~data_n[7:0];
        if (last_write && lanes[1]) mem[last_addr[3:0]][15:8] = ~data_n[15:8];
        repeat (delay) @(posedge clk);
        if (!last_write) begin
            rdata_n <= ~mem[last_addr[3:0]];
            rdata_oe <= 1'h1;
            @(posedge clk);
        end
        if (fault) fault_n <= 1'h0;
        else ack_n <= 1'h0;
        wait (strobe.data_lane0_strobe_n && strobe.data_lane1_strobe_n);
        rdata_oe <= 1'h0;
        rdata_n <= ~rdata_n; // Floating lanes must not keep old data
        @(posedge clk);
        ack_n <= 1'h1;
        fault_n <= 1'h1;
    end
endmodule // absh_slave_model

// ===== tb/absh_master_bench.sv
// Purpose: Self-checking bench for the strobe bus master
// Assumes: 50 MHz clock, slave model on the far side
// Notes: Shared lines are wired-AND of two holders
`timescale 1ns/100ps
module absh_master_bench
    import absh_pkg::*;
();
    logic clk, rst_n, req_valid, req_ready, rsp_valid, addr_oe, data_oe, write_n, ctrl_oe, strobe_oe;
    logic other_oe, sl_oe, ack_n, fault_n, sl_fault, wide_n;
    absh_req_t req;
    absh_rsp_t rsp;
    logic [ABSH_ADDR_W-1:0] addr_n;
    logic [ABSH_DATA_W-1:0] data_o, data_i, sl_data;
    absh_strobe_t strobe_o, strobe_i, other_strobe;
    logic [3:0] sl_delay;
    logic [12:0] hold_a, hold_b, shared_n, pend;
    int num_errors, num_checks, cyc;
    // Undriven strobes pulled high; idle data shows the model's pattern
    assign strobe_i = strobe_oe ? strobe_o : (other_oe ? other_strobe : 3'h7);
    assign data_i = data_oe ? data_o : sl_data;
    assign shared_n = hold_a & hold_b;
    absh_master absh_master_inst (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ(req), .RSP_VALID(rsp_valid), .RSP(rsp), .ADDR_N_O(addr_n), .ADDR_N_OE(addr_oe), .DATA_N_O(data_o),
        .DATA_N_OE(data_oe), .DATA_N_I(data_i), .WRITE_N_O(write_n), .WIDE_XFER_N_O(wide_n), .CTRL_N_OE(ctrl_oe),
        .STROBE_O(strobe_o), .STROBE_OE(strobe_oe), .STROBE_I(strobe_i), .XFER_ACK_N(ack_n),
        .BUS_FAULT_N(fault_n), .IRQ_LEVEL_N(shared_n[6:0]), .BUS_REQ_LEVEL_N(shared_n[11:7]),
        .SYS_FAILURE_N(shared_n[12]), .IRQ_PENDING(pend[6:0]), .BUS_REQ_PENDING(pend[11:7]),
        .SYS_FAILED(pend[12]));
    absh_slave_model absh_slave_model_inst (.clk(clk), .strobe(strobe_i), .addr_n(addr_n), .write_n(write_n),
        .data_n(data_i), .delay(sl_delay), .fault(sl_fault), .rdata_n(sl_data), .rdata_oe(sl_oe),
        .ack_n(ack_n), .fault_n(fault_n));
    // Clock at 20 ns
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // One transfer, held until taken, then wait for completion
    task automatic xfer(input logic rd, input logic [1:0] ln, input logic [3:0] ad, input logic [15:0] wd,
        output absh_rsp_t r);
        req_valid <= 1'h1;
        req <= '{addr: {27'h5555555, ad}, wdata: wd, lanes: ln, read: rd, wide: ad[0]};
        do @(posedge clk); while (req_ready !== 1'h1);
        req_valid <= 1'h0;
        do @(posedge clk); while (rsp_valid !== 1'h1);
        r = rsp;
        check("addr", absh_slave_model_inst.last_addr, {27'h5555555, ad});
        check("dir", absh_slave_model_inst.last_write, !rd);
        check("wide", wide_n, !ad[0]);
    endtask
    task automatic t_rw();
        absh_rsp_t r;
        for (int d = 0; d < 13; d += 12) begin
            sl_delay <= 4'(d);
            xfer(1'h0, 2'h3, 4'(d), 16'hBEEF ^ 16'(d), r);
            check("wr fault", r.fault, 1'h0);
            xfer(1'h1, 2'h3, 4'(d), 16'h0000, r);
            check("rd data", r.rdata, 16'hBEEF ^ 16'(d));
            check("rd oe", sl_oe, 1'h0);
        end
        $display("rw done");
    endtask
    task automatic t_lanes();
        absh_rsp_t r;
        xfer(1'h0, 2'h3, 4'h9, 16'h1234, r);
        xfer(1'h0, 2'h1, 4'h9, 16'hAACD, r);
        xfer(1'h0, 2'h2, 4'h9, 16'hEF00, r);
        xfer(1'h1, 2'h1, 4'h9, 16'h0000, r);
        check("lane0", r.rdata[7:0], 8'hCD);
        xfer(1'h1, 2'h3, 4'h9, 16'h0000, r);
        check("lanes", r.rdata, 16'hEFCD);
        $display("lanes done");
    endtask
    task automatic t_fault();
        absh_rsp_t r;
        sl_fault <= 1'h1;
        xfer(1'h0, 2'h3, 4'h2, 16'h7777, r);
        check("wr flt", r.fault, 1'h1);
        xfer(1'h1, 2'h1, 4'h2, 16'h0000, r);
        check("rd flt", r.fault, 1'h1);
        sl_fault <= 1'h0;
        xfer(1'h1, 2'h3, 4'h9, 16'h0000, r);
        check("no flt", r.fault, 1'h0);
        check("no flt rd", r.rdata, 16'hEFCD);
        $display("fault done");
    endtask
    // Lane0 strobe held low by another module
    task automatic t_owner();
        absh_rsp_t r;
        other_strobe <= 3'h5;
        other_oe <= 1'h1;
        fork
            xfer(1'h1, 2'h3, 4'h9, 16'h0000, r);
            begin
                repeat (30) @(posedge clk);
                check("no take", strobe_oe, 1'h0);
                other_strobe <= 3'h7;
                @(posedge clk);
                other_oe <= 1'h0;
                repeat (ABSH_OWN_WAIT_CYC) @(posedge clk);
                check("own wait", strobe_oe, 1'h0);
            end
        join
        check("own rd", r.rdata, 16'hEFCD);
        $display("owner done");
    endtask
    // Requests held with no time limit by two holders
    task automatic t_shared();
        hold_a <= 13'h0AAA;
        repeat (50) @(posedge clk);
        check("pend", pend, 13'h1555);
        hold_b <= 13'h0AAA;
        hold_a <= 13'h1FFF;
        repeat (4) @(posedge clk);
        check("one held", pend, 13'h1555);
        hold_b <= 13'h1FFF;
        repeat (4) @(posedge clk);
        check("clear", pend, 13'h0000);
        $display("shared done");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // Reset then scenarios
    initial begin
        rst_n = 1'h0;
        req_valid = 1'h0;
        req = '0;
        other_oe = 1'h0;
        other_strobe = 3'h7;
        hold_a = 13'h1FFF;
        hold_b = 13'h1FFF;
        sl_delay = 4'h0;
        sl_fault = 1'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_rw();
        t_lanes();
        t_fault();
        t_owner();
        t_shared();
        conclude();
    end
endmodule // absh_master_bench
bind absh_master absh_master_asserts absh_master_asserts_inst (.CLK(CLK), .RST_N(RST_N), .RSP_VALID(RSP_VALID),
    .ADDR_N_O(ADDR_N_O), .ADDR_N_OE(ADDR_N_OE), .DATA_N_OE(DATA_N_OE), .WRITE_N_O(WRITE_N_O),
    .CTRL_N_OE(CTRL_N_OE), .STROBE_O(STROBE_O), .STROBE_OE(STROBE_OE), .STROBE_I(STROBE_I),
    .XFER_ACK_N(XFER_ACK_N), .BUS_FAULT_N(BUS_FAULT_N), .IRQ_LEVEL_N(IRQ_LEVEL_N), .IRQ_PENDING(IRQ_PENDING));
